/* hdl/eqr_pkg.sv */
// Purpose: Shared constants for the error queue reporter
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   Codes are signed 16-bit two's complement
package eqr_pkg;
   localparam int          EQR_DEPTH      = 30;
   localparam int          EQR_ORD_SLOTS  = 29;
   localparam int          EQR_CODE_W     = 16;
   localparam int          EQR_PTR_W      = 5;
   localparam int          EQR_CNT_W      = 5;
   localparam int          EQR_ADDR_W     = 8;

   // Register byte offsets
   localparam logic [7:0]  EQR_OFS_QUEUE  = 8'h00;
   localparam logic [7:0]  EQR_OFS_STATUS = 8'h04;
   localparam logic [7:0]  EQR_OFS_ESR    = 8'h08;
   localparam logic [7:0]  EQR_OFS_CTRL   = 8'h0c;
   localparam logic [7:0]  EQR_OFS_LAST   = 8'h10;

   // Event status bit positions
   localparam int          EQR_ESR_CMD    = 5;
   localparam int          EQR_ESR_EXE    = 4;
   localparam int          EQR_ESR_DEV    = 3;
   localparam int          EQR_ESR_QRY    = 2;
   localparam logic [5:0]  EQR_ESR_MASK   = 6'h3c;
   localparam logic [5:0]  EQR_ESR_RST    = 6'h00;

   // Control bit: write one to clear status
   localparam int          EQR_CTRL_CLS   = 0;

   // Status field positions
   localparam int          EQR_ST_EMPTY   = 8;
   localparam int          EQR_ST_OVF     = 9;

   // Error codes
   localparam logic signed [15:0] EQR_NO_ERR   = 16'sh0000;
   localparam logic signed [15:0] EQR_CMD_GEN  = -16'sd100;
   localparam logic signed [15:0] EQR_CMD_END  = -16'sd199;
   localparam logic signed [15:0] EQR_CMD_GET  = -16'sd105;
   localparam logic signed [15:0] EQR_EXE_GEN  = -16'sd200;
   localparam logic signed [15:0] EQR_EXE_END  = -16'sd299;
   localparam logic signed [15:0] EQR_DEV_GEN  = -16'sd300;
   localparam logic signed [15:0] EQR_DEV_END  = -16'sd399;
   localparam logic signed [15:0] EQR_Q_OVF    = -16'sd350;
   localparam logic signed [15:0] EQR_QRY_GEN  = -16'sd400;
   localparam logic signed [15:0] EQR_QRY_END  = -16'sd499;

   // Message text identifiers, resolved to strings by software
   typedef enum logic [2:0] {
      EQR_TXT_NONE = 3'b000,
      EQR_TXT_CMD  = 3'b001,
      EQR_TXT_GET  = 3'b010,
      EQR_TXT_EXE  = 3'b011,
      EQR_TXT_DEV  = 3'b100,
      EQR_TXT_OVF  = 3'b101,
      EQR_TXT_QRY  = 3'b110,
      EQR_TXT_INST = 3'b111
   } eqr_txt_e;
endpackage : eqr_pkg

/* hdl/eqr_top.sv */
// Purpose: Error queue with event status bits, reached over APB
// Assumes: Error inputs are synchronous to ref_clk; at most one is queued per cycle
// Notes:   Queue read pops; LAST holds the code and text id of it
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
module eqr_top
   import eqr_pkg::*;
#(
   parameter int DEPTH = EQR_DEPTH
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst_b,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [EQR_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]            pwdata,
   output      logic [31:0]            prdata,
   output      logic                   pready,
   output      logic                   pslverr,
   input  wire logic                   err_valid,
   input  wire logic [EQR_CODE_W-1:0]  err_code,
   input  wire logic                   get_in_msg,
   input  wire logic                   outq_underrun,
   input  wire logic                   outq_lost,
   output      logic                   queue_empty
);

   logic [EQR_CODE_W-1:0]  mem_ff [DEPTH];
   logic [EQR_PTR_W-1:0]   head_ff;
   logic [EQR_PTR_W-1:0]   tail_ff;
   logic [EQR_CNT_W-1:0]   count_ff;
   logic                   ovf_ff;
   logic [5:0]             esr_ff;
   logic [EQR_CODE_W-1:0]  last_ff;
   logic                   pend_pop_ff;
   logic [31:0]            prdata_ff;

   logic                   setup;
   logic                   access;
   logic                   mapped;
   logic                   pop;
   logic                   cls;
   logic                   esr_clr_wr;
   logic                   push;
   logic [EQR_CODE_W-1:0]  push_code;
   logic [EQR_CNT_W-1:0]   eff_count;
   logic                   store_err;
   logic                   store_ovf;
   logic [3:0]             push_cls;
   logic [5:0]             esr_set;

   function automatic logic [3:0] eqr_class(input logic [15:0] c);
      logic signed [15:0] s;
      s = c;
      // Returns one-hot {cmd, exe, dev, qry}
      eqr_class = 4'h0;
      if (s <= EQR_CMD_GEN && s >= EQR_CMD_END)
         eqr_class = 4'h8;
      else if (s <= EQR_EXE_GEN && s >= EQR_EXE_END)
         eqr_class = 4'h4;
      else if ((s <= EQR_DEV_GEN && s >= EQR_DEV_END) || s > 0)
         eqr_class = 4'h2;
      else if (s <= EQR_QRY_GEN && s >= EQR_QRY_END)
         eqr_class = 4'h1;
   endfunction : eqr_class

   function automatic eqr_txt_e eqr_text(input logic [15:0] c);
      logic [3:0] k;
      k = eqr_class(c);
      // Unlisted negative codes fall back to their class's generic text; positive codes get the INST text
      if (c == EQR_CMD_GET)
         eqr_text = EQR_TXT_GET;
      else if (c == EQR_Q_OVF)
         eqr_text = EQR_TXT_OVF;
      else if (k[3])
         eqr_text = EQR_TXT_CMD;
      else if (k[2])
         eqr_text = EQR_TXT_EXE;
      else if (k[1] && $signed(c) > 0)
         eqr_text = EQR_TXT_INST;
      else if (k[1])
         eqr_text = EQR_TXT_DEV;
      else if (k[0])
         eqr_text = EQR_TXT_QRY;
      else
         eqr_text = EQR_TXT_NONE;
   endfunction : eqr_text

   // APB decode; zero wait states
   assign setup   = psel && !penable;
   assign access  = psel && penable;
   assign mapped  = (paddr == EQR_OFS_QUEUE) || (paddr == EQR_OFS_STATUS) ||
                    (paddr == EQR_OFS_ESR) || (paddr == EQR_OFS_CTRL) ||
                    (paddr == EQR_OFS_LAST);
   assign pready  = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata  = prdata_ff;
   assign pop     = access && pend_pop_ff;
   assign cls     = access && pwrite && (paddr == EQR_OFS_CTRL) &&
                    pwdata[EQR_CTRL_CLS];
   assign esr_clr_wr = access && pwrite && (paddr == EQR_OFS_ESR);

   // One entry per cycle; a command error suppresses the rest
   always_comb begin
      push      = 1'b0;
      push_code = EQR_NO_ERR;
      if (get_in_msg) begin
         push      = 1'b1;
         push_code = EQR_CMD_GET;
      end else if (err_valid && err_code != EQR_NO_ERR) begin
         push      = 1'b1;
         push_code = err_code;
      end else if (outq_underrun || outq_lost) begin
         push      = 1'b1;
         push_code = EQR_QRY_GEN;
      end
   end

   // Pop frees its slot before a same-cycle push is placed
   assign eff_count = count_ff - EQR_CNT_W'(pop);
   assign store_err = push && !cls &&
                      (eff_count < EQR_CNT_W'(EQR_ORD_SLOTS));
   assign store_ovf = push && !cls &&
                      (eff_count == EQR_CNT_W'(EQR_ORD_SLOTS));

   always_ff @(posedge ref_clk) begin
      if (store_err)
         mem_ff[tail_ff] <= push_code;
      else if (store_ovf)
         mem_ff[tail_ff] <= EQR_Q_OVF;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         head_ff  <= '0;
         tail_ff  <= '0;
         count_ff <= '0;
         ovf_ff   <= 1'b0;
      end else if (cls) begin
         head_ff  <= '0;
         tail_ff  <= '0;
         count_ff <= '0;
         ovf_ff   <= 1'b0;
      end else begin
         if (pop)
            head_ff <= (head_ff == EQR_PTR_W'(DEPTH - 1)) ? '0 :
                       head_ff + 1'b1;
         if (store_err || store_ovf)
            tail_ff <= (tail_ff == EQR_PTR_W'(DEPTH - 1)) ? '0 :
                       tail_ff + 1'b1;
         count_ff <= eff_count + EQR_CNT_W'(store_err || store_ovf);
         // Besides a clear-status write, the overflow flag clears only when a read empties the queue
         if (store_ovf)
            ovf_ff <= 1'b1;
         else if (pop && eff_count == '0)
            ovf_ff <= 1'b0;
      end
   end

   // Status bits: set wins over a write-one clear
   always_comb begin
      push_cls = eqr_class(push_code);
      esr_set  = '0;
      if (push) begin
         esr_set[EQR_ESR_CMD] = push_cls[3];
         esr_set[EQR_ESR_EXE] = push_cls[2];
         esr_set[EQR_ESR_DEV] = push_cls[1] || store_ovf;
         esr_set[EQR_ESR_QRY] = push_cls[0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         esr_ff <= EQR_ESR_RST;
      end else if (cls) begin
         esr_ff <= esr_set;
      end else if (esr_clr_wr) begin
         esr_ff <= (esr_ff & ~pwdata[5:0]) | esr_set;
      end else begin
         esr_ff <= esr_ff | esr_set;
      end
   end

   // Read data is captured in setup, so the pop lands in access
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_ff   <= '0;
         pend_pop_ff <= 1'b0;
      end else if (setup && !pwrite) begin
         pend_pop_ff <= (paddr == EQR_OFS_QUEUE) && (count_ff != '0);
         unique case (paddr)
            EQR_OFS_QUEUE:
               prdata_ff <= (count_ff == '0) ? 32'h0000_0000 :
                            {{16{mem_ff[head_ff][15]}}, mem_ff[head_ff]};
            EQR_OFS_STATUS:
               prdata_ff <= {22'h0, ovf_ff, (count_ff == '0),
                             3'h0, count_ff};
            EQR_OFS_ESR:
               prdata_ff <= {26'h0, esr_ff & EQR_ESR_MASK};
            EQR_OFS_LAST:
               prdata_ff <= {13'h0, eqr_text(last_ff), last_ff};
            default:
               prdata_ff <= 32'h0000_0000;
         endcase
      end else if (!setup) begin
         pend_pop_ff <= 1'b0;
      end
   end

   // Keeps the last answer for the text lookup
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         last_ff <= EQR_NO_ERR;
      else if (access && !pwrite && paddr == EQR_OFS_QUEUE)
         last_ff <= pop ? mem_ff[head_ff] : EQR_NO_ERR;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         queue_empty <= 1'b1;
      else
         queue_empty <= (count_ff == '0);
   end

   // Checks
   a_count_cap: assert property (@(posedge ref_clk) disable iff (!rst_b)
      count_ff <= EQR_CNT_W'(DEPTH))
      else $error("queue count above depth");

   a_empty_read_zero: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (setup && !pwrite && paddr == EQR_OFS_QUEUE && count_ff == '0)
      |=> (prdata == 32'h0000_0000 && !pend_pop_ff))
      else $error("empty queue read not zero");

   a_pop_drains: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (pop && !push && !cls) |=> (count_ff == $past(count_ff) - 1'b1))
      else $error("read did not remove entry");

   a_head_order: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (pop && !cls) |=> (head_ff != $past(head_ff)))
      else $error("head did not advance");

   a_overflow_mark: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (push && !pop && !cls && count_ff == EQR_CNT_W'(EQR_ORD_SLOTS))
      |=> (ovf_ff && count_ff == EQR_CNT_W'(DEPTH) &&
           esr_ff[EQR_ESR_DEV]))
      else $error("overflow marker missing");

   a_full_drop: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (push && !pop && !cls && count_ff == EQR_CNT_W'(DEPTH))
      |=> $stable(count_ff) ##0 $stable(tail_ff))
      else $error("full queue accepted entry");

   a_cls_clears: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      cls |=> (count_ff == '0 && !ovf_ff) ##1 queue_empty)
      else $error("clear status left entries");

   a_get_cmd_bit: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      get_in_msg |=> esr_ff[EQR_ESR_CMD])
      else $error("trigger error not flagged");

   a_cmd_excl: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (get_in_msg && !esr_ff[EQR_ESR_EXE] && !esr_ff[EQR_ESR_QRY])
      |=> (!esr_ff[EQR_ESR_EXE] && !esr_ff[EQR_ESR_QRY]))
      else $error("command error raised another class");

   a_exe_bit: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (push && eqr_class(push_code) == 4'h4) |=> esr_ff[EQR_ESR_EXE])
      else $error("execution bit not set");

   a_qry_bit: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (outq_underrun && !get_in_msg && !err_valid) |=> esr_ff[EQR_ESR_QRY])
      else $error("query bit not set");

   // Class bits, read-out path and slot accounting
   a_cmd_bit: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (push && eqr_class(push_code) == 4'h8) |=> esr_ff[EQR_ESR_CMD])
      else $error("command bit not set");

   a_dev_bit: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (push && eqr_class(push_code) == 4'h2) |=> esr_ff[EQR_ESR_DEV])
      else $error("device bit not set");

   a_one_class: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (push && !store_ovf) |-> $onehot0(esr_set))
      else $error("one event raised two classes");

   a_lost_qry: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (outq_lost && !get_in_msg && !err_valid) |=> esr_ff[EQR_ESR_QRY])
      else $error("lost output not flagged");

   a_get_queued: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (get_in_msg && !access && count_ff == '0)
      |=> (count_ff == EQR_CNT_W'(1) && mem_ff[head_ff] == EQR_CMD_GET))
      else $error("trigger error not queued");

   a_last_match: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      pop |=> (last_ff == prdata[15:0]))
      else $error("last code differs from answer");

   a_empty_last: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (access && !pwrite && paddr == EQR_OFS_QUEUE && !pend_pop_ff)
      |=> (last_ff == EQR_NO_ERR))
      else $error("empty read left a stale code");

   a_zero_ignored: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (err_valid && err_code == EQR_NO_ERR && !get_in_msg &&
       !outq_underrun && !outq_lost && !access)
      |=> ($stable(count_ff) && $stable(esr_ff)))
      else $error("zero code was queued");

   a_push_grows: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (push && !pop && !cls && count_ff < EQR_CNT_W'(EQR_ORD_SLOTS))
      |=> (count_ff == $past(count_ff) + 1'b1 && !$stable(tail_ff)))
      else $error("error not appended");

   a_pop_frees: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (pop && push && count_ff == EQR_CNT_W'(EQR_ORD_SLOTS))
      |=> (count_ff == EQR_CNT_W'(EQR_ORD_SLOTS) && $stable(ovf_ff)))
      else $error("read did not free a slot");

   a_last_empties: assert property (@(posedge ref_clk)
      disable iff (!rst_b)
      (pop && !push && count_ff == EQR_CNT_W'(1))
      |=> (count_ff == '0 && !ovf_ff))
      else $error("last read left the queue busy");

   c_overflow: cover property (@(posedge ref_clk) disable iff (!rst_b)
      store_ovf);
   c_read_empty: cover property (@(posedge ref_clk) disable iff (!rst_b)
      access && !pwrite && paddr == EQR_OFS_QUEUE && !pend_pop_ff);
   c_pop_push: cover property (@(posedge ref_clk) disable iff (!rst_b)
      pop && store_err);
   c_cls: cover property (@(posedge ref_clk) disable iff (!rst_b)
      cls && count_ff != '0);
   c_get_with_err: cover property (@(posedge ref_clk) disable iff (!rst_b)
      get_in_msg && err_valid);

endmodule : eqr_top

/* dv/eqr_host.sv */
// Purpose: Host controller model issuing register transfers over APB
// Assumes: Slave answers with pready; no fixed latency is assumed
// Notes:   One idle cycle separates successive transfers
`timescale 1ns/1ns
module eqr_host (
   input  wire logic        ref_clk,
   output      logic        psel,
   output      logic        penable,
   output      logic        pwrite,
   output      logic [7:0]  paddr,
   output      logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
   end

   // Request is held until pready is seen high at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~d;
   endtask : xfer
endmodule : eqr_host

/* dv/eqr_top_bench.sv */
// Purpose: Self-checking bench for the error queue reporter
// Assumes: Zero-wait APB slave, error inputs are one-cycle pulses
// Notes:   Expected codes are computed here, never read back first
`timescale 1ns/1ns
module eqr_top_bench;
   import eqr_pkg::*;
   logic        ref_clk, rst_b, psel, penable, pwrite;
   logic        pready, pslverr, queue_empty;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        err_valid, get_in_msg, outq_underrun, outq_lost, e;
   logic [15:0] err_code;
   int          miscompares = 0;
   int          n_tests     = 0;

   eqr_top eqr_top_inst (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .err_valid(err_valid), .err_code(err_code), .get_in_msg(get_in_msg),
      .outq_underrun(outq_underrun), .outq_lost(outq_lost),
      .queue_empty(queue_empty));
   eqr_host eqr_host_inst (.ref_clk(ref_clk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd(string what, logic [7:0] a, logic [31:0] exp);
      eqr_host_inst.xfer(1'b0, a, 32'h0, q, e);
      check(what, q, exp);
   endtask : rd

   task automatic wr(logic [7:0] a, logic [31:0] d);
      eqr_host_inst.xfer(1'b1, a, d, q, e);
   endtask : wr

   // Pop reads the queue, then LAST holds the text id of that entry
   task automatic pop(logic [15:0] c, eqr_txt_e t);
      rd("queue", EQR_OFS_QUEUE, {{16{c[15]}}, c});
      rd("last", EQR_OFS_LAST, {13'h0, t, c});
   endtask : pop

   task automatic pulse(logic g, logic v, logic [15:0] c, logic u,
                        logic l);
      @(posedge ref_clk);
      get_in_msg    <= g;
      err_valid     <= v;
      err_code      <= c;
      outq_underrun <= u;
      outq_lost     <= l;
      @(posedge ref_clk);
      {get_in_msg, err_valid, outq_underrun, outq_lost} <= 4'h0;
   endtask : pulse

   task automatic push(logic [15:0] c);
      pulse(1'b0, 1'b1, c, 1'b0, 1'b0);
   endtask : push

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   // Whole run is about five hundred cycles; this is far beyond it
   initial begin
      repeat (50000) @(posedge ref_clk);
      miscompares++;
      finish_test();
   end

   logic [15:0] cc [6] = '{-16'sd100, -16'sd299, -16'sd300, 16'sd1,
                            -16'sd499, 16'sd32767};
   eqr_txt_e    ct [6] = '{EQR_TXT_CMD, EQR_TXT_EXE, EQR_TXT_DEV,
                            EQR_TXT_INST, EQR_TXT_QRY, EQR_TXT_INST};

   initial begin
      rst_b = 1'b0;
      {get_in_msg, err_valid, outq_underrun, outq_lost} = 4'h0;
      err_code = 16'h0;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      check("queue_empty", {31'h0, queue_empty}, 32'h1);
      rd("status", EQR_OFS_STATUS, 32'h100);
      rd("esr", EQR_OFS_ESR, 32'h0);
      pop(EQR_NO_ERR, EQR_TXT_NONE);
      pop(EQR_NO_ERR, EQR_TXT_NONE);
      // Code zero means no error and must not take a slot
      push(16'h0);
      rd("status", EQR_OFS_STATUS, 32'h100);
      $display("test reset done");

      for (int i = 0; i < 6; i++) push(cc[i]);
      rd("esr", EQR_OFS_ESR, 32'h3c);
      for (int i = 0; i < 6; i++)
         pop(cc[i], ct[i]);
      repeat (2) @(posedge ref_clk);
      check("queue_empty", {31'h0, queue_empty}, 32'h1);
      wr(EQR_OFS_ESR, 32'h3c);
      rd("esr", EQR_OFS_ESR, 32'h0);
      $display("test classes done");

      pulse(1'b1, 1'b1, -16'sd222, 1'b0, 1'b0);
      pulse(1'b0, 1'b0, 16'h0, 1'b1, 1'b0);
      pulse(1'b0, 1'b0, 16'h0, 1'b0, 1'b1);
      rd("esr", EQR_OFS_ESR, 32'h24);
      pop(EQR_CMD_GET, EQR_TXT_GET);
      pop(EQR_QRY_GEN, EQR_TXT_QRY);
      pop(EQR_QRY_GEN, EQR_TXT_QRY);
      push(-16'sd150);
      wr(EQR_OFS_CTRL, 32'h1);
      rd("status", EQR_OFS_STATUS, 32'h100);
      rd("esr", EQR_OFS_ESR, 32'h0);
      $display("test events done");

      for (int i = 0; i < 31; i++) push(16'(-201 - i));
      rd("status", EQR_OFS_STATUS, 32'h21e);
      for (int i = 0; i < 29; i++) pop(16'(-201 - i), EQR_TXT_EXE);
      pop(EQR_Q_OVF, EQR_TXT_OVF);
      rd("status", EQR_OFS_STATUS, 32'h100);
      $display("test overflow done");

      for (int i = 0; i < 29; i++) push(16'(-201 - i));
      pop(-16'sd201, EQR_TXT_EXE);
      push(-16'sd250);
      rd("status", EQR_OFS_STATUS, 32'h01d);
      // Error lands on the access edge of the read that frees a slot
      fork
         rd("queue", EQR_OFS_QUEUE, 32'hffff_ff36);
         begin
            @(posedge ref_clk);
            push(-16'sd252);
         end
      join
      rd("status", EQR_OFS_STATUS, 32'h01d);
      push(-16'sd251);
      rd("status", EQR_OFS_STATUS, 32'h21e);
      wr(EQR_OFS_CTRL, 32'h1);
      rd("status", EQR_OFS_STATUS, 32'h100);
      $display("test tail done");

      push(-16'sd120);
      rd("status", EQR_OFS_STATUS, 32'h001);
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      check("queue_empty", {31'h0, queue_empty}, 32'h1);
      rd("status", EQR_OFS_STATUS, 32'h100);
      rd("esr", EQR_OFS_ESR, 32'h0);
      pop(EQR_NO_ERR, EQR_TXT_NONE);
      $display("test second reset done");

      rd("unmapped", 8'h20, 32'h0);
      check("pslverr", {31'h0, e}, 32'h1);
      $display("test unmapped done");
      finish_test();
   end
endmodule : eqr_top_bench
